// File: adc_conv_pkg.sv
package adc_conv_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h04;
  localparam logic [7:0] OFF_CTRL       = 8'h08;
  localparam logic [7:0] OFF_THRESH     = 8'h0C;
  localparam logic [7:0] OFF_CONFIG     = 8'h10;
  localparam logic [7:0] OFF_RESULT     = 8'h14;
  localparam logic [7:0] OFF_ENGINE     = 8'h18;

  // Serial register pointer values
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;

  // Interrupt status bit positions
  localparam int IRQ_CONV_DONE = 0;
  localparam int IRQ_REG_WRITE = 1;
  localparam int IRQ_ADDR_HIT  = 2;
  localparam int IRQ_BITS      = 3;

  // Serial config register field positions
  localparam int CFG_START     = 15;
  localparam int CFG_SINGLE    = 8;
  localparam int CFG_RATE_LSB  = 5;
  localparam int CFG_READY_SEL = 2;

  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0180;
  localparam logic [6:0]  ADDR_RESET   = 7'h48;
  localparam logic [11:0] THRESH_RESET = 12'h7FF;

  // Conversion timing
  localparam int CLK_FREQ_HZ = 250_000_000;

  // Conversion rate in samples per second for each rate code
  function automatic int rate_sps(input logic [2:0] code);
    case (code)
      3'h0:    rate_sps = 128;
      3'h1:    rate_sps = 250;
      3'h2:    rate_sps = 490;
      3'h3:    rate_sps = 920;
      3'h4:    rate_sps = 1600;
      3'h5:    rate_sps = 2400;
      default: rate_sps = 3300;
    endcase
  endfunction

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_RX    = 3'b001,
    SER_ACK   = 3'b010,
    SER_TX    = 3'b011,
    SER_TXACK = 3'b100
  } ser_state_t;

  typedef enum logic [0:0] {
    ENG_SHUTDOWN = 1'b0,
    ENG_CONVERT  = 1'b1
  } eng_state_t;

  // Register write from the serial port
  typedef struct packed {
    logic        strobe;
    logic [7:0]  pointer;
    logic [15:0] data;
  } ser_write_t;

  // Conversion control bundle
  typedef struct packed {
    logic       start;
    logic       single;
    logic [2:0] rate;
  } conv_ctrl_t;

endpackage

// File: adc_serial_slave.sv
`timescale 1ns/1ps
module adc_serial_slave
  import adc_conv_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output wire logic       sda_out,
  output wire logic       sda_oe,
  input  wire logic [6:0] slave_addr,
  input  wire logic [15:0] rd_data,
  output ser_write_t      wr,
  output logic            addr_hit,
  output logic            rd_result
);

  ser_state_t state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic       is_read;
  logic       addr_phase;
  logic       tx_lsb;
  logic [7:0] msb_hold;

  // Two-stage synchronisers for the bus pins, then a delay stage for edges
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end

  // Bus conditions; start and stop are only seen while the clock is high
  wire logic scl_s    = scl_sync[1];
  wire logic sda_s    = sda_sync[1];
  wire logic start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire logic stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire logic scl_rise = scl_s & ~scl_d;
  wire logic scl_fall = ~scl_s & scl_d;
  wire logic full     = bit_cnt == 4'h8;
  wire logic addr_ok  = shreg[7:1] == slave_addr;
  wire logic [7:0] next_tx = tx_lsb ? rd_data[7:0] : rd_data[15:8];

  // Pin driven only low: acknowledge, or a zero data bit while sending
  assign sda_out = 1'b0;
  assign sda_oe  = (state == SER_ACK) | ((state == SER_TX) & ~shreg[7]);

  // Byte engine: receive, acknowledge, transmit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state      <= SER_IDLE;
      shreg      <= 8'h00;
      bit_cnt    <= 4'h0;
      byte_idx   <= 2'h0;
      is_read    <= 1'b0;
      addr_phase <= 1'b0;
      tx_lsb     <= 1'b0;
      msb_hold   <= 8'h00;
      wr         <= '0;
      addr_hit   <= 1'b0;
      rd_result  <= 1'b0;
    end
    else
    begin
      wr.strobe <= 1'b0;
      addr_hit  <= 1'b0;
      rd_result <= 1'b0;
      if (start_c)
      begin
        state      <= SER_RX;
        bit_cnt    <= 4'h0;
        addr_phase <= 1'b1;
        byte_idx   <= 2'h0;
      end
      else if (stop_c)
        state <= SER_IDLE;
      else
        unique case (state)
          SER_IDLE: ;
          SER_RX:
            if (scl_rise && !full)
            begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && full)
            begin
              bit_cnt <= 4'h0;
              if (addr_phase)
              begin
                addr_phase <= 1'b0;
                if (addr_ok)
                begin
                  state    <= SER_ACK;
                  is_read  <= shreg[0];
                  tx_lsb   <= 1'b0;
                  addr_hit <= 1'b1;
                end
                else
                  state <= SER_IDLE;
              end
              else
              begin
                state <= SER_ACK;
                unique case (byte_idx)
                  2'h0: wr.pointer <= shreg;
                  2'h1: msb_hold <= shreg;
                  default:
                  begin
                    wr.data   <= {msb_hold, shreg};
                    wr.strobe <= 1'b1;
                  end
                endcase
                byte_idx <= (byte_idx == 2'h2) ? 2'h1 : byte_idx + 2'h1;
              end
            end
          SER_ACK:
            if (scl_fall)
            begin
              if (is_read)
              begin
                state     <= SER_TX;
                shreg     <= next_tx;
                tx_lsb    <= ~tx_lsb;
                rd_result <= (wr.pointer == PTR_RESULT) & tx_lsb;
              end
              else
                state <= SER_RX;
            end
          SER_TX:
            if (scl_fall)
            begin
              if (bit_cnt == 4'h7)
              begin
                state   <= SER_TXACK;
                bit_cnt <= 4'h0;
              end
              else
              begin
                shreg   <= {shreg[6:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          SER_TXACK:
            if (scl_rise && sda_s)
              state <= SER_IDLE;                              // Master declined more data
            else if (scl_fall)
            begin
              state     <= SER_TX;
              shreg     <= next_tx;
              tx_lsb    <= ~tx_lsb;
              rd_result <= (wr.pointer == PTR_RESULT) & tx_lsb;
            end
          default: state <= SER_IDLE;
        endcase
    end

endmodule

// File: adc_conv_engine.sv
`timescale 1ns/1ps
module adc_conv_engine
  import adc_conv_pkg::*;
#(
  parameter int CLK_HZ = CLK_FREQ_HZ
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  conv_ctrl_t       ctrl,
  input  wire logic [11:0] sample,
  output logic [15:0]      result,
  output logic             done,
  output logic             busy
);

  eng_state_t state;
  logic [31:0] count;

  // Cycles of one conversion at the selected data rate
  wire logic [31:0] period = 32'(CLK_HZ / rate_sps(ctrl.rate));
  wire logic        finish = (state == ENG_CONVERT) && (count <= 32'h1);

  assign busy = state == ENG_CONVERT;

  // Shutdown until requested; continuous mode restarts at once
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state  <= ENG_SHUTDOWN;
      count  <= 32'h0;
      result <= 16'h0000;
      done   <= 1'b0;
    end
    else
    begin
      done <= finish;
      unique case (state)
        ENG_SHUTDOWN:
          if (ctrl.start || !ctrl.single)
          begin
            state <= ENG_CONVERT;
            count <= period;
          end
        ENG_CONVERT:
          if (finish)
          begin
            result <= {sample, 4'h0};
            if (ctrl.single)
              state <= ENG_SHUTDOWN;
            else
              count <= period;
          end
          else
            count <= count - 32'h1;
      endcase
    end

endmodule

// File: adc_i2c_conversion_control.sv
`timescale 1ns/1ps
module adc_i2c_conversion_control
  import adc_conv_pkg::*;
#(
  parameter int CLK_HZ = CLK_FREQ_HZ
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe,
  input  wire logic [1:0]  addr_sel,
  input  wire logic [11:0] sample,
  output logic             alert_rdy,
  output wire logic        irq
);

  logic [15:0]         config_reg;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [6:0]          addr_base;
  logic [11:0]         thresh;
  logic [1:0]          sel_meta;
  logic [1:0]          sel_sync;
  logic                start_req;
  logic                ready_flag;
  ser_write_t          ser_wr;
  logic [15:0]         ser_rd_data;
  logic                addr_hit;
  logic                rd_result;
  logic [15:0]         result;
  logic                conv_done;
  logic                busy;
  conv_ctrl_t          ctrl;

  // Address select pins cross into the clock domain through two stages
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end
    else
    begin
      sel_meta <= addr_sel;
      sel_sync <= sel_meta;
    end

  wire logic [6:0] slave_addr = {addr_base[6:2], sel_sync};

  // Serial slave port
  adc_serial_slave u_serial (
    .pclk       (pclk),
    .presetn    (presetn),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .slave_addr (slave_addr),
    .rd_data    (ser_rd_data),
    .wr         (ser_wr),
    .addr_hit   (addr_hit),
    .rd_result  (rd_result)
  );

  // Register selected by the pointer; config start bit reads as idle
  wire logic        ptr_result  = ser_wr.pointer == PTR_RESULT;
  wire logic        ptr_config  = ser_wr.pointer == PTR_CONFIG;
  wire logic [15:0] config_view = {~busy, config_reg[14:0]};
  assign ser_rd_data = ptr_result ? result :
                       ptr_config ? config_view : 16'h0000;
  wire logic        cfg_write   = ser_wr.strobe & ptr_config;

  // Config register and single-shot request
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      config_reg <= CONFIG_RESET;
      start_req  <= 1'b0;
    end
    else
    begin
      if (cfg_write)
        config_reg <= ser_wr.data;
      start_req <= cfg_write & ser_wr.data[CFG_START] & ser_wr.data[CFG_SINGLE];
    end

  assign ctrl.start  = start_req;
  assign ctrl.single = config_reg[CFG_SINGLE];
  assign ctrl.rate   = config_reg[CFG_RATE_LSB +: 3];

  // Conversion timing and result capture
  adc_conv_engine #(
    .CLK_HZ (CLK_HZ)
  ) u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .ctrl    (ctrl),
    .sample  (sample),
    .result  (result),
    .done    (conv_done),
    .busy    (busy)
  );

  // Alert/ready pin: ready flag or comparator, chosen by config
  wire logic over_thresh = $signed(result[15:4]) > $signed(thresh);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ready_flag <= 1'b0;
      alert_rdy  <= 1'b0;
    end
    else
    begin
      if (conv_done)
        ready_flag <= 1'b1;                                   // Set wins over a clear
      else if (rd_result)
        ready_flag <= 1'b0;
      alert_rdy <= config_reg[CFG_READY_SEL] ? ready_flag : over_thresh;
    end

  // APB decode; the slave always answers in the access cycle
  wire logic apb_wr     = psel & penable & pwrite;
  wire logic hit_status = paddr == OFF_IRQ_STATUS;
  wire logic hit_mask   = paddr == OFF_IRQ_MASK;
  wire logic hit_ctrl   = paddr == OFF_CTRL;
  wire logic hit_thresh = paddr == OFF_THRESH;
  wire logic hit_config = paddr == OFF_CONFIG;
  wire logic hit_result = paddr == OFF_RESULT;
  wire logic hit_engine = paddr == OFF_ENGINE;
  wire logic mapped     = hit_status | hit_mask | hit_ctrl | hit_thresh |
                          hit_config | hit_result | hit_engine;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire logic [IRQ_BITS-1:0] irq_events = {addr_hit, ser_wr.strobe, conv_done};
  wire logic [IRQ_BITS-1:0] irq_clear  = (apb_wr & hit_status) ? pwdata[IRQ_BITS-1:0] :
                                         {IRQ_BITS{1'b0}};

  // Software registers and sticky interrupt status
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
      addr_base  <= ADDR_RESET;
      thresh     <= THRESH_RESET;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;   // Set wins over clear
      if (apb_wr && hit_mask)
        irq_mask <= pwdata[IRQ_BITS-1:0];
      if (apb_wr && hit_ctrl)
        addr_base <= pwdata[6:0];
      if (apb_wr && hit_thresh)
        thresh <= pwdata[11:0];
    end

  assign irq = |(irq_status & irq_mask);

  // Read data mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (hit_status)
      prdata[IRQ_BITS-1:0] = irq_status;
    else if (hit_mask)
      prdata[IRQ_BITS-1:0] = irq_mask;
    else if (hit_ctrl)
      prdata[6:0] = addr_base;
    else if (hit_thresh)
      prdata[11:0] = thresh;
    else if (hit_config)
      prdata[15:0] = config_view;
    else if (hit_result)
      prdata[15:0] = result;
    else if (hit_engine)
      prdata[1:0] = {ready_flag, busy};
  end

endmodule

// File: adc_ctrl_sva.sv
`timescale 1ns/1ps
module adc_ctrl_sva
  import adc_conv_pkg::*;
#(
  parameter int CLK_HZ = CLK_FREQ_HZ
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq
);
  logic       scl_q;
  logic [3:0] since_fall;
  // Access phase and address decode
  wire        acc    = psel && penable;
  wire        mapped = paddr inside {OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_CTRL,
                       OFF_THRESH, OFF_CONFIG, OFF_RESULT, OFF_ENGINE};
  // Cycles since the last serial clock fall, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q      <= 1'b1;
      since_fall <= 4'hF;
    end
    else
    begin
      scl_q      <= scl_in;
      since_fall <= (scl_q && !scl_in) ? 4'h0 : (since_fall == 4'hF ? 4'hF : since_fall + 4'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  oe_edge_a: assert property ($changed(sda_oe) |-> since_fall <= 4'h6)
    else $error("sda_oe moved away from a clock fall");
  drain_a: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  ready_a: assert property (acc |-> pready)
    else $error("pready low in access");
  bad_addr_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  irq_sticky_a: assert property (irq && !(acc && pwrite) |=> irq)
    else $error("irq dropped without a write");
  irq_mask_a: assert property (acc && pwrite && paddr == OFF_IRQ_MASK && pwdata == 32'h0 |=> !irq)
    else $error("irq high with all masked");
  reset_out_a: assert property ($rose(presetn) |-> !irq && !sda_oe)
    else $error("outputs active after reset");
  cover property ($rose(irq));
  cover property ($rose(sda_oe));
  cover property (acc && pslverr);
endmodule
bind adc_i2c_conversion_control adc_ctrl_sva #(.CLK_HZ(CLK_HZ)) adc_ctrl_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// File: i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
(
  input  wire logic pclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus: clock parked high, data released to the pull-up
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter of the 160 ns link period
  task automatic qtr();
    repeat (10) @(posedge pclk);
  endtask
  // One bit: data set while the clock is low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask
  // Start: data falls while the clock is high
  task automatic start();
    sda_low <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask
  // Stop: data rises while the clock is high, clock then stands still
  task automatic stop();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask
  // Byte out, most significant bit first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in; more selects acknowledge or not-acknowledge
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, r);
  endtask
endmodule

// File: test_adc_i2c_conversion_control.sv
`timescale 1ns/1ps
module test_adc_i2c_conversion_control
  import adc_conv_pkg::*;
;
  localparam int CLK_HZ = 1_600_000;
  localparam int PER    = CLK_HZ / 1600; // Rate code 4
  typedef struct packed { logic [7:0] a; logic [31:0] v; logic e; } row_t;
  logic        pclk, presetn, psel, penable, pwrite, scl, sda_low, ack, err;
  logic        pready, pslverr, sda_out, sda_oe, alert_rdy, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  addr_sel;
  logic [11:0] sample;
  logic [15:0] v16;
  int          n_errors, samples_checked, t1;
  int          cyc = 0;
  wire         sda = !(sda_low || sda_oe);
  row_t        rows [7] = '{'{OFF_IRQ_STATUS, 32'h0, 1'b0}, '{OFF_IRQ_MASK, 32'h0, 1'b0},
                 '{OFF_CTRL, 32'h48, 1'b0}, '{OFF_THRESH, 32'h7FF, 1'b0},
                 '{OFF_RESULT, 32'h0, 1'b0}, '{OFF_ENGINE, 32'h0, 1'b0}, '{8'h1C, 32'h0, 1'b1}};
  adc_i2c_conversion_control #(.CLK_HZ(CLK_HZ)) adc_i2c_conversion_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .sample(sample), .alert_rdy(alert_rdy), .irq(irq));
  i2c_host_model i2c_host_model_i (.pclk(pclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // Clock and cycle count
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = !pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Serial write: address, pointer, then an optional word
  task automatic swrite(input logic [7:0] ptr, input logic [15:0] v, input logic dat);
    i2c_host_model_i.start();
    i2c_host_model_i.wbyte(8'h90, ack);
    chk("addr ack", ack, 1'h1);
    i2c_host_model_i.wbyte(ptr, ack);
    chk("ptr ack", ack, 1'h1);
    if (dat)
    begin
      i2c_host_model_i.wbyte(v[15:8], ack);
      chk("msb ack", ack, 1'h1);
      i2c_host_model_i.wbyte(v[7:0], ack);
      chk("lsb ack", ack, 1'h1);
    end
    i2c_host_model_i.stop();
  endtask
  task automatic sread(output logic [15:0] v);
    i2c_host_model_i.start();
    i2c_host_model_i.wbyte(8'h91, ack);
    i2c_host_model_i.rbyte(1'b1, v[15:8]);
    i2c_host_model_i.rbyte(1'b0, v[7:0]);
    i2c_host_model_i.stop();
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
    chk("irq", irq, 1'h1);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 14000 cycles
  initial
  begin
    #200_000;
    n_errors++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, addr_sel} = '0;
    sample = 12'h5A3;
    n_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reset read", rd, rows[i].v);
      chk("slave error", err, rows[i].e);
    end
    $display("Done: register table");
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    swrite(PTR_CONFIG, 16'h8184, 1'b1);
    wait_irq();
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk("status", rd, 32'h7);
    repeat (2) @(posedge pclk);
    chk("ready pin", alert_rdy, 1'h1);
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("result", rd, {16'h0, sample, 4'h0});
    swrite(PTR_RESULT, 16'h0, 1'b0);
    sread(v16);
    chk("serial result", v16, {sample, 4'h0});
    chk("ready clear", alert_rdy, 1'h0);
    apb(1'b1, OFF_IRQ_STATUS, 32'h7);
    repeat (PER + 200) @(posedge pclk);
    apb(1'b0, OFF_ENGINE, 32'h0);
    chk("idle", rd, 32'h0);
    chk("no rerun", irq, 1'h0);
    swrite(PTR_CONFIG, 16'h0, 1'b0);
    sread(v16);
    chk("config", v16, 16'h8184);
    i2c_host_model_i.start();
    i2c_host_model_i.wbyte(8'h92, ack);
    i2c_host_model_i.stop();
    chk("foreign addr", ack, 1'h0);
    $display("Done: single-shot");
    apb(1'b1, OFF_THRESH, 32'h100);
    sample <= 12'h123;
    swrite(PTR_CONFIG, 16'h8080, 1'b1);
    wait_irq();
    t1 = cyc;
    apb(1'b1, OFF_IRQ_STATUS, 32'h1);
    wait_irq();
    chk("period", cyc - t1, PER);
    chk("alert high", alert_rdy, 1'h1);
    sample <= 12'h0A5;
    apb(1'b1, OFF_IRQ_STATUS, 32'h1);
    wait_irq();
    repeat (2) @(posedge pclk);
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("latest result", rd, 32'h0A50);
    chk("alert low", alert_rdy, 1'h0);
    swrite(PTR_CONFIG, 16'h0180, 1'b1);
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    chk("masked", irq, 1'h0);
    $display("Done: continuous");
    report_and_stop();
  end
endmodule
